// File: src/wdt_top.v
// Watchdog timer with AXI4-Lite register access
`timescale 1ns/10ps
`include "wdt_defines.vh"

// Contract
// - Counter overflow raises the internal reset output.
// - A 13-bit prescaler advances on every enabled system clock cycle.
// - Counter is 8-bit readable, writable, counting on system clock divided by 8192.
// - Overflow comes after 256 minus reload value ticks of 8192 cycles.
// - Control bit 7 written 1 keeps bit 6; written 0 lets it change.
// - While control bit 6 is set, counter accepts 8-bit writes.
// - Control bit 5 written 1 keeps bit 4; written 0 lets it change.
// - While control bit 4 is set, bits 2 and 0 may be written.
// - Control bit 3 written 1 keeps bit 2; written 0 lets it change.
// - Counting and overflow reset happen only while control bit 2 is set.
// - Control bit 1 written 1 keeps bit 0; written 0 lets it change.
// - Control bit 0 reads 1 after an overflow or a software write of 1, else 0.
// - Clock select 0 picks system clock divided by 8192 as tick.
// - Clock select 1 picks low-speed subclock divided by 32 as tick.

module wdt_top #(
	parameter ADDR_W = `WDT_ADDR_W,
	parameter PRESCALE_W = `WDT_PRESCALE_W
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire subclk,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	output reg wdt_reset,
	output reg irq
);

	////////////////////////////////////////////////////////////////////////////
	// State

	reg counter_write_enable;
	reg control_write_enable;
	reg watchdog_on;
	reg overflow_reset_flag;
	reg watchdog_clock_select;
	reg [`WDT_COUNT_W-1:0] watchdog_counter;
	reg irq_status;
	reg irq_mask;
	reg [`WDT_RST_LEN_W-1:0] rst_cnt;

	reg sub_s1;
	reg sub_s2;
	reg sub_s3;
	reg [`WDT_SUB_DIV_W-1:0] sub_div;

	reg aw_full;
	reg w_full;
	reg [`WDT_IDX_W-1:0] wr_idx;
	reg [7:0] wr_byte;
	reg wr_lane0;

	wire pre_tick;
	wire [PRESCALE_W-1:0] system_prescaler;

	////////////////////////////////////////////////////////////////////////////
	// Prescaler

	wdt_prescaler #(
		.WIDTH(PRESCALE_W)
	) u_prescaler (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.tick(pre_tick),
		.count(system_prescaler)
	);

	////////////////////////////////////////////////////////////////////////////
	// Subclock divider

	// Subclock is asynchronous: two flops before use
	always @(posedge aclk) begin
		if (!aresetn) begin
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end else if (ce) begin
			sub_s1 <= subclk;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end

	wire sub_rise = ce & sub_s2 & ~sub_s3;
	wire sub_tick = sub_rise & (sub_div == `WDT_SUB_DIV_MAX);

	// Divides subclock rising edges by 32
	always @(posedge aclk) begin
		if (!aresetn) begin
			sub_div <= {`WDT_SUB_DIV_W{1'b0}};
		end else if (sub_rise) begin
			sub_div <= sub_div + {{(`WDT_SUB_DIV_W-1){1'b0}}, 1'b1};
		end
	end

	// Tick source selection
	wire count_tick = watchdog_clock_select ? sub_tick : pre_tick;

	////////////////////////////////////////////////////////////////////////////
	// Write channel

	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire do_write = ce & aw_full & w_full & ~s_axi_bvalid;
	wire b_done = s_axi_bvalid & s_axi_bready;

	wire wr_ctrl = do_write & wr_lane0 & (wr_idx == `WDT_IDX_CTRL);
	wire wr_count = do_write & wr_lane0 & (wr_idx == `WDT_IDX_COUNT);
	wire wr_stat = do_write & wr_lane0 & (wr_idx == `WDT_IDX_IRQ_STATUS);
	wire wr_mask = do_write & wr_lane0 & (wr_idx == `WDT_IDX_IRQ_MASK);
	wire wr_sel = do_write & wr_lane0 & (wr_idx == `WDT_IDX_CLK_SEL);
	wire wr_mapped = (wr_idx == `WDT_IDX_CTRL) | (wr_idx == `WDT_IDX_COUNT) |
		(wr_idx == `WDT_IDX_IRQ_STATUS) | (wr_idx == `WDT_IDX_IRQ_MASK) |
		(wr_idx == `WDT_IDX_CLK_SEL);

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WDT_RESP_OKAY;
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_idx <= {`WDT_IDX_W{1'b0}};
			wr_byte <= 8'h00;
			wr_lane0 <= 1'b0;
		end else if (ce) begin
			if (aw_take) begin
				aw_full <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_idx <= s_axi_awaddr[`WDT_IDX_MSB:`WDT_IDX_LSB];
			end
			if (w_take) begin
				w_full <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_byte <= s_axi_wdata[7:0];
				wr_lane0 <= s_axi_wstrb[0];
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_mapped ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
			end
			if (b_done) begin
				s_axi_bvalid <= 1'b0;
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Watchdog counter

	// Software reload wins over a tick in the same cycle
	wire count_load = wr_count & counter_write_enable;
	wire count_step = ce & watchdog_on & count_tick & ~count_load;
	// Overflow only while enabled
	wire overflow = count_step & (watchdog_counter == `WDT_COUNT_MAX);

	always @(posedge aclk) begin
		if (!aresetn) begin
			watchdog_counter <= `WDT_RST_COUNT;
		end else if (count_load) begin
			watchdog_counter <= wr_byte;
		end else if (count_step) begin
			watchdog_counter <= watchdog_counter + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control and status

	always @(posedge aclk) begin
		if (!aresetn) begin
			counter_write_enable <= `WDT_RST_CNT_WE;
			control_write_enable <= `WDT_RST_CTRL_WE;
			watchdog_on <= `WDT_RST_ON;
			overflow_reset_flag <= `WDT_RST_FLAG;
			watchdog_clock_select <= `WDT_RST_CLK_SEL;
			irq_mask <= `WDT_RST_IRQ;
		end else if (ce) begin
			if (wr_ctrl && !wr_byte[`WDT_BIT_INH6]) begin
				counter_write_enable <= wr_byte[`WDT_BIT_CNT_WE];
			end
			if (wr_ctrl && !wr_byte[`WDT_BIT_INH4]) begin
				control_write_enable <= wr_byte[`WDT_BIT_CTRL_WE];
			end
			if (wr_ctrl && control_write_enable && !wr_byte[`WDT_BIT_INH2]) begin
				watchdog_on <= wr_byte[`WDT_BIT_ON];
			end
			// Hardware set beats a software write in the same cycle
			if (overflow) begin
				overflow_reset_flag <= 1'b1;
			end else if (wr_ctrl && control_write_enable && !wr_byte[`WDT_BIT_INH0]) begin
				overflow_reset_flag <= wr_byte[`WDT_BIT_FLAG];
			end
			if (wr_sel) begin
				watchdog_clock_select <= wr_byte[`WDT_BIT_CLK_SEL];
			end
			if (wr_mask) begin
				irq_mask <= wr_byte[`WDT_BIT_IRQ_OVF];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Internal reset and interrupt

	always @(posedge aclk) begin
		if (!aresetn) begin
			rst_cnt <= {`WDT_RST_LEN_W{1'b0}};
			wdt_reset <= 1'b0;
			irq_status <= `WDT_RST_IRQ;
			irq <= 1'b0;
		end else if (ce) begin
			if (overflow) begin
				rst_cnt <= `WDT_RST_LEN;
			end else if (rst_cnt != {`WDT_RST_LEN_W{1'b0}}) begin
				rst_cnt <= rst_cnt - {{(`WDT_RST_LEN_W-1){1'b0}}, 1'b1};
			end
			wdt_reset <= overflow | (rst_cnt > `WDT_RST_LEN_END);
			// Sticky, write one to clear, set wins
			if (overflow) begin
				irq_status <= 1'b1;
			end else if (wr_stat && wr_byte[`WDT_BIT_IRQ_OVF]) begin
				irq_status <= 1'b0;
			end
			irq <= irq_status & irq_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read channel

	wire ar_take = ce & s_axi_arvalid & s_axi_arready;
	wire [`WDT_IDX_W-1:0] rd_idx = s_axi_araddr[`WDT_IDX_MSB:`WDT_IDX_LSB];
	reg [7:0] rd_byte;
	reg rd_hit;

	// Inhibit bits are not stored and read as one
	always @* begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		case (rd_idx)
			`WDT_IDX_CTRL: begin
				rd_byte[`WDT_BIT_INH6] = 1'b1;
				rd_byte[`WDT_BIT_CNT_WE] = counter_write_enable;
				rd_byte[`WDT_BIT_INH4] = 1'b1;
				rd_byte[`WDT_BIT_CTRL_WE] = control_write_enable;
				rd_byte[`WDT_BIT_INH2] = 1'b1;
				rd_byte[`WDT_BIT_ON] = watchdog_on;
				rd_byte[`WDT_BIT_INH0] = 1'b1;
				rd_byte[`WDT_BIT_FLAG] = overflow_reset_flag;
			end
			`WDT_IDX_COUNT: begin
				rd_byte = watchdog_counter;
			end
			`WDT_IDX_IRQ_STATUS: begin
				rd_byte[`WDT_BIT_IRQ_OVF] = irq_status;
			end
			`WDT_IDX_IRQ_MASK: begin
				rd_byte[`WDT_BIT_IRQ_OVF] = irq_mask;
			end
			`WDT_IDX_CLK_SEL: begin
				rd_byte[`WDT_BIT_CLK_SEL] = watchdog_clock_select;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `WDT_RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_byte};
				s_axi_rresp <= rd_hit ? `WDT_RESP_OKAY : `WDT_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule

// File: src/wdt_defines.vh
// Constants for the watchdog timer block
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH

`define WDT_ADDR_W 18
`define WDT_IDX_W 16
`define WDT_IDX_LSB 2
`define WDT_IDX_MSB 17

`define WDT_IDX_CTRL 16'hFFC0
`define WDT_IDX_COUNT 16'hFFC1
`define WDT_IDX_IRQ_STATUS 16'hFFC2
`define WDT_IDX_IRQ_MASK 16'hFFC3
`define WDT_IDX_CLK_SEL 16'hFFE0

`define WDT_BIT_INH6 7
`define WDT_BIT_CNT_WE 6
`define WDT_BIT_INH4 5
`define WDT_BIT_CTRL_WE 4
`define WDT_BIT_INH2 3
`define WDT_BIT_ON 2
`define WDT_BIT_INH0 1
`define WDT_BIT_FLAG 0
`define WDT_BIT_CLK_SEL 2
`define WDT_BIT_IRQ_OVF 0

`define WDT_RST_CNT_WE 1'b0
`define WDT_RST_CTRL_WE 1'b0
`define WDT_RST_ON 1'b0
`define WDT_RST_FLAG 1'b0
`define WDT_RST_COUNT 8'h00
`define WDT_RST_CLK_SEL 1'b0
`define WDT_RST_IRQ 1'b0

`define WDT_PRESCALE_W 13
`define WDT_COUNT_W 8
`define WDT_COUNT_MAX 8'hFF
`define WDT_SUB_DIV_W 5
`define WDT_SUB_DIV_MAX 5'h1F
`define WDT_RST_LEN_W 3
`define WDT_RST_LEN 3'h4
`define WDT_RST_LEN_END 3'h1

`define WDT_RESP_OKAY 2'h0
`define WDT_RESP_SLVERR 2'h2

`endif

// File: src/wdt_prescaler.v
// Free-running system clock prescaler with terminal tick
`timescale 1ns/10ps
`include "wdt_defines.vh"

module wdt_prescaler #(
	parameter WIDTH = `WDT_PRESCALE_W
) (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	output wire tick,
	output reg [WIDTH-1:0] count
);

	// Counts every enabled system cycle
	always @(posedge aclk) begin
		if (!aresetn) begin
			count <= {WIDTH{1'b0}};
		end else if (ce) begin
			count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// One tick per full wrap, clock divided by two to the width
	assign tick = ce & (&count);

endmodule

// File: test/wdt_properties.sv
// Checker for the watchdog reset output and register bus handshakes
`timescale 1ns/10ps
module wdt_checker (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic wdt_reset
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////
reset_pulse_len_a: assert property ($rose(wdt_reset) |-> wdt_reset [*4] ##1 !wdt_reset)
	else $error("internal reset pulse length wrong");
write_answer_time_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
	&& s_axi_wready |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid)
	else $error("write response timing wrong");
write_resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
	s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
read_answer_time_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read data late");
read_data_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
	s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
read_upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
	else $error("read data upper bits set");
read_busy_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
	else $error("read address taken while busy");
write_busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
	else $error("write taken while busy");
endmodule
bind wdt_top wdt_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .wdt_reset);

// File: test/watchdog_timer_w_test.sv
// Self-checking testbench for the watchdog timer
`timescale 1ns/10ps
`include "wdt_defines.vh"
module watchdog_timer_w_test;
logic aclk = 1'h0, aresetn = 1'h0, subclk = 1'h0, ce = 1'h1;
logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
logic [31:0] s_axi_wdata = 32'h00000000;
logic [2:0] sdiv = 3'h0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdt_reset, irq;
wire [1:0] s_axi_bresp, s_axi_rresp;
wire [31:0] s_axi_rdata;
int error_cnt = 0, comparisons = 0, n;
logic [33:0] rows [0:14] = '{
	{`WDT_IDX_CTRL, 8'h40, 8'hEA, 2'h0},
	{`WDT_IDX_CTRL, 8'h50, 8'hFA, 2'h0},
	{`WDT_IDX_CTRL, 8'hAA, 8'hFA, 2'h0},
	{`WDT_IDX_CTRL, 8'h51, 8'hFB, 2'h0},
	{`WDT_IDX_CTRL, 8'h52, 8'hFB, 2'h0},
	{`WDT_IDX_CTRL, 8'h40, 8'hEA, 2'h0},
	{`WDT_IDX_CTRL, 8'h65, 8'hEA, 2'h0},
	{`WDT_IDX_COUNT, 8'h5A, 8'h5A, 2'h0},
	{`WDT_IDX_CTRL, 8'h10, 8'hBA, 2'h0},
	{`WDT_IDX_COUNT, 8'h33, 8'h5A, 2'h0},
	{`WDT_IDX_CTRL, 8'h50, 8'hFA, 2'h0},
	{`WDT_IDX_IRQ_MASK, 8'h01, 8'h01, 2'h0},
	{`WDT_IDX_IRQ_STATUS, 8'h00, 8'h00, 2'h0},
	{`WDT_IDX_CLK_SEL, 8'h04, 8'h04, 2'h0},
	{16'h0010, 8'h00, 8'h00, 2'h2}};
////////////////////////////////////////////////////////////////
always #4 aclk = ~aclk;
always @(posedge aclk) begin
	sdiv <= sdiv + 3'h1;
	subclk <= sdiv[2];
end
wdt_top #(.PRESCALE_W(4)) uut (.aclk, .aresetn, .ce, .subclk, .s_axi_awaddr,
	.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1),
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .wdt_reset, .irq);
////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] s, input logic [31:0] e);
	comparisons++;
	if (s !== e) begin
		error_cnt++;
		$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask
task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er);
	int k = 0;
	s_axi_awaddr <= {i, 2'h0};
	s_axi_wdata <= {24'h000000, d};
	s_axi_awvalid <= 1'h1;
	s_axi_wvalid <= 1'h1;
	s_axi_bready <= 1'h1;
	while (k < 50) begin
		@(posedge aclk);
		k++;
		if (s_axi_awready) s_axi_awvalid <= 1'h0;
		if (s_axi_wready) s_axi_wvalid <= 1'h0;
		if (s_axi_bvalid) begin
			chk(32'(s_axi_bresp), 32'(er));
			k = 100;
		end
	end
	s_axi_bready <= 1'h0;
	@(posedge aclk);
	chk(32'(k), 32'h64);
endtask
task automatic rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er);
	int k = 0;
	s_axi_araddr <= {i, 2'h0};
	s_axi_arvalid <= 1'h1;
	s_axi_rready <= 1'h1;
	while (k < 50) begin
		@(posedge aclk);
		k++;
		if (s_axi_arready) s_axi_arvalid <= 1'h0;
		if (s_axi_rvalid) begin
			chk(32'(s_axi_rresp), 32'(er));
			if (er == 2'h0) chk(s_axi_rdata, {24'h000000, e});
			k = 100;
		end
	end
	s_axi_rready <= 1'h0;
	@(posedge aclk);
	chk(32'(k), 32'h64);
endtask
task automatic wait_rst();
	n = 0;
	while (wdt_reset !== 1'h1 && n < 2000) begin
		@(posedge aclk);
		n++;
	end
endtask
task automatic give_verdict();
	$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
	if (error_cnt == 0 && comparisons > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
endtask
////////////////////////////////////////////////////////////////
initial begin
	#200000;
	error_cnt++;
	give_verdict();
end
initial begin
	repeat (12) @(posedge aclk);
	aresetn <= 1'h1;
	@(posedge aclk);
	foreach (rows[r]) begin
		wr(rows[r][33:18], rows[r][17:10], rows[r][1:0]);
		rd(rows[r][33:18], rows[r][9:2], rows[r][1:0]);
	end
	wr(`WDT_IDX_CLK_SEL, 8'h00, 2'h0);
	// Reload then enable, overflow after 16 ticks of 16 cycles
	wr(`WDT_IDX_COUNT, 8'hF0, 2'h0);
	wr(`WDT_IDX_CTRL, 8'h54, 2'h0);
	wait_rst();
	chk(32'(n >= 238 && n <= 262), 32'h1);
	rd(`WDT_IDX_CTRL, 8'hFF, 2'h0);
	rd(`WDT_IDX_IRQ_STATUS, 8'h01, 2'h0);
	chk(32'(irq), 32'h1);
	wr(`WDT_IDX_IRQ_MASK, 8'h00, 2'h0);
	repeat (2) @(posedge aclk);
	chk(32'(irq), 32'h0);
	wr(`WDT_IDX_IRQ_MASK, 8'h01, 2'h0);
	wr(`WDT_IDX_IRQ_STATUS, 8'h01, 2'h0);
	repeat (2) @(posedge aclk);
	chk(32'(irq), 32'h0);
	// Disabled counter holds even at its top value
	wr(`WDT_IDX_CTRL, 8'h50, 2'h0);
	wr(`WDT_IDX_COUNT, 8'hFF, 2'h0);
	repeat (100) @(posedge aclk);
	rd(`WDT_IDX_COUNT, 8'hFF, 2'h0);
	rd(`WDT_IDX_CTRL, 8'hFA, 2'h0);
	chk(32'(wdt_reset), 32'h0);
	// Frozen clock enable shifts overflow by the frozen span
	wr(`WDT_IDX_COUNT, 8'hF0, 2'h0);
	wr(`WDT_IDX_CTRL, 8'h54, 2'h0);
	ce <= 1'h0;
	repeat (300) @(posedge aclk);
	ce <= 1'h1;
	wait_rst();
	chk(32'(n >= 240 && n <= 255), 32'h1);
	// Subclock source, three ticks of 32 rises 8 cycles apart
	wr(`WDT_IDX_CLK_SEL, 8'h04, 2'h0);
	wr(`WDT_IDX_COUNT, 8'hFD, 2'h0);
	wr(`WDT_IDX_CTRL, 8'h54, 2'h0);
	wait_rst();
	chk(32'(n >= 505 && n <= 770), 32'h1);
	aresetn <= 1'h0;
	repeat (12) @(posedge aclk);
	aresetn <= 1'h1;
	@(posedge aclk);
	rd(`WDT_IDX_CTRL, 8'hAA, 2'h0);
	rd(`WDT_IDX_COUNT, 8'h00, 2'h0);
	rd(`WDT_IDX_CLK_SEL, 8'h00, 2'h0);
	chk(32'(irq), 32'h0);
	give_verdict();
end
endmodule
